// >>> logic/seecm_regs.svh
// Purpose: constants of the serial eeprom command engine
// Assumes: a 20 MHz core clock
// Notes: definitions only
`ifndef SEECM_REGS_SVH
`define SEECM_REGS_SVH

`define SEECM_CLK_PERIOD_NS 50
`define SEECM_TWR_NS 5000000
`define SEECM_MEM_BYTES 256
`define SEECM_PAGE_BYTES 16
`define SEECM_ADDR_W 8
`define SEECM_COL_W 4
`define SEECM_BITS_DONE 4'h8
`define SEECM_SLOT_END 4'h9
`define SEECM_RW_BIT 0
`define SEECM_CS_MSB 3
`define SEECM_CS_LSB 1
`define SEECM_TYPE_MSB 7
`define SEECM_TYPE_LSB 4

`endif

// >>> logic/seecm_pkg.sv
// Purpose: types of the serial eeprom command engine
// Assumes: nothing
// Notes: states of the bus command sequencer
package seecm_pkg;

    typedef enum logic [2:0] {
        SEECM_IDLE,
        SEECM_DEV,
        SEECM_WADDR,
        SEECM_WDATA,
        SEECM_RDATA,
        SEECM_PROG
    } seecm_state_e;

    typedef logic [7:0] seecm_byte_t;

endpackage

// >>> logic/seecm_pin_if.sv
// Purpose: filtered pin levels and bus events
// Assumes: one clock domain
// Notes: produced by the pin synchroniser
`timescale 1ns/1ps
`default_nettype none

interface seecm_pin_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic wp;
    logic [2:0] cs;

    modport prod (output scl, sda, scl_rise, scl_fall, start, stop, wp, cs);
    modport cons (input scl, sda, scl_rise, scl_fall, start, stop, wp, cs);
endinterface

`default_nettype wire

// >>> logic/seecm_pin_sync.sv
// Purpose: three-stage pin synchroniser and bus event detector
// Assumes: pins asynchronous to CLOCK
// Notes: a level counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module seecm_pin_sync
    import seecm_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic nrst, // async reset, low
    input wire logic scl_pin, // serial clock pin
    input wire logic sda_pin, // serial data pin
    input wire logic wp_pin, // write protect pin
    input wire logic [2:0] cs_pin, // chip select pins
    seecm_pin_if.prod pins // filtered levels and events
);
    localparam int W = 6;

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] next_lvl;
    logic scl_q;
    logic sda_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1 <= 6'h03;
            s2 <= 6'h03;
            s3 <= 6'h03;
        end
        else
        begin
            s1 <= {cs_pin, wp_pin, sda_pin, scl_pin};
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            next_lvl[i] = (s2[i] == s3[i]) ? s3[i] : lvl[i];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lvl <= 6'h03;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            lvl <= next_lvl;
            scl_q <= lvl[0];
            sda_q <= lvl[1];
        end
    end

    // start and stop only while the clock stays high
    assign pins.scl = lvl[0];
    assign pins.sda = lvl[1];
    assign pins.wp = lvl[2];
    assign pins.cs = lvl[5:3];
    assign pins.scl_rise = lvl[0] & ~scl_q;
    assign pins.scl_fall = ~lvl[0] & scl_q;
    assign pins.start = lvl[0] & scl_q & sda_q & ~lvl[1];
    assign pins.stop = lvl[0] & scl_q & ~sda_q & lvl[1];
endmodule

`default_nettype wire

// >>> logic/seecm_core.sv
// Purpose: command engine of a 256-byte two-wire serial eeprom target
// Assumes: bus controller drives SCL; all pins sampled by CLOCK
// Notes: array content is not cleared by reset; programming is self-timed
`timescale 1ns/1ps
`default_nettype none
`include "seecm_regs.svh"

// Function
// - address byte: type, chip select, direction
// - acknowledge each received byte low on ninth clock
// - write protect high blocks programming only
// - write address acked only on select match
// - word address follows, acked at clock eighteen
// - byte write data acked at clock 27
// - stop after data starts programming, bus ignored
// - programming time elapsed returns to standby
// - page write programs one to sixteen bytes
// - further data words acked every nine clocks
// - only low four column bits increment
// - page may start anywhere, partial allowed
// - beyond sixteen words the column wraps
// - no acknowledge while programming, polling works
// - read uses direction bit set to one
// - counter holds last address plus one; after a write the column wraps within the row
// - current read acks, sends byte, increments
// - read ends on no acknowledge then stop
// - controller acknowledge fetches next sequential byte
// - read counter wraps from top to zero
// - random read: dummy write then read
// - start during write abandons pending programming
module seecm_core
    import seecm_pkg::*;
#(
    parameter int PROG_CYCLES = `SEECM_TWR_NS / `SEECM_CLK_PERIOD_NS,
    parameter logic [3:0] TYPE_CODE = 4'h5 // arbitrary value
)
(
    input wire logic CLOCK, // core clock, 20 MHz
    input wire logic NRST, // async reset, active low
    input wire logic SCL_IN, // serial clock pin
    input wire logic SDA_IN, // serial data pin level
    output logic SDA_OUT, // serial data drive value
    output logic SDA_OE_N, // low while pulling data low
    input wire logic [2:0] CHIP_SELECT_PINS, // chip select straps
    input wire logic WRITE_PROTECT, // high blocks programming
    output logic BUSY // self-timed programming active
);
    seecm_pin_if pins ();

    seecm_pin_sync u_sync (
        .clk(CLOCK),
        .nrst(NRST),
        .scl_pin(SCL_IN),
        .sda_pin(SDA_IN),
        .wp_pin(WRITE_PROTECT),
        .cs_pin(CHIP_SELECT_PINS),
        .pins(pins)
    );

    seecm_byte_t mem [`SEECM_MEM_BYTES];
    seecm_byte_t pbuf [`SEECM_PAGE_BYTES];
    logic [`SEECM_PAGE_BYTES-1:0] pvalid;
    seecm_state_e state;
    seecm_state_e next_state;
    logic [3:0] bit_cnt;
    seecm_byte_t shift;
    seecm_byte_t tx;
    logic [`SEECM_ADDR_W-1:0] addr;
    logic [31:0] timer;
    logic mack;
    logic next_drive;
    logic in_prog;
    logic ev_rise;
    logic ev_fall;
    logic ev_start;
    logic ev_stop;
    logic ack_fall;
    logic slot_end;
    logic addr_match;
    logic prog_done;
    logic go_prog;
    logic load_rd;

    // column step inside the current row
    function automatic logic [`SEECM_ADDR_W-1:0] col_next(
        input logic [`SEECM_ADDR_W-1:0] a);
        col_next = {a[`SEECM_ADDR_W-1:`SEECM_COL_W], a[`SEECM_COL_W-1:0] + 4'h1};
    endfunction

    function automatic logic dev_hit(
        input seecm_byte_t b,
        input logic [2:0] cs);
        dev_hit = (b[`SEECM_TYPE_MSB:`SEECM_TYPE_LSB] == TYPE_CODE)
            && (b[`SEECM_CS_MSB:`SEECM_CS_LSB] == cs);
    endfunction

    // bus events are dropped while programming
    assign in_prog = (state == SEECM_PROG);
    assign ev_rise = pins.scl_rise & ~in_prog;
    assign ev_fall = pins.scl_fall & ~in_prog;
    assign ev_start = pins.start & ~in_prog;
    assign ev_stop = pins.stop & ~in_prog;
    assign ack_fall = ev_fall && (bit_cnt == `SEECM_BITS_DONE);
    assign slot_end = ev_fall && (bit_cnt == `SEECM_SLOT_END);
    assign addr_match = dev_hit(shift, pins.cs);
    assign prog_done = in_prog && (timer == 32'(PROG_CYCLES - 1));
    // the clock rise that carries stop has already counted one bit
    assign go_prog = (state == SEECM_WDATA) && (bit_cnt <= 4'h1)
        && (|pvalid) && !pins.wp;
    assign load_rd = slot_end && (((state == SEECM_DEV) && mack && shift[`SEECM_RW_BIT])
        || ((state == SEECM_RDATA) && mack));

    // command sequencer
    always_comb
    begin
        next_state = state;
        if (prog_done)
        begin
            next_state = SEECM_IDLE;
        end
        else if (ev_start)
        begin
            next_state = SEECM_DEV;
        end
        else if (ev_stop)
        begin
            next_state = go_prog ? SEECM_PROG : SEECM_IDLE;
        end
        else if (slot_end)
        begin
            case (state)
                SEECM_DEV:
                begin
                    if (!mack)
                    begin
                        next_state = SEECM_IDLE;
                    end
                    else if (shift[`SEECM_RW_BIT])
                    begin
                        next_state = SEECM_RDATA;
                    end
                    else
                    begin
                        next_state = SEECM_WADDR;
                    end
                end
                SEECM_WADDR:
                begin
                    next_state = SEECM_WDATA;
                end
                SEECM_WDATA:
                begin
                    next_state = SEECM_WDATA;
                end
                SEECM_RDATA:
                begin
                    next_state = mack ? SEECM_RDATA : SEECM_IDLE;
                end
                default:
                begin
                    next_state = SEECM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            state <= SEECM_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // bit position within the nine-clock word
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            bit_cnt <= 4'h0;
        end
        else if (ev_start || ev_stop || slot_end)
        begin
            bit_cnt <= 4'h0;
        end
        else if (ev_rise && (bit_cnt < `SEECM_SLOT_END) && (state != SEECM_IDLE))
        begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // receive shifter, sampled on clock rise
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            shift <= 8'h00;
        end
        else if (ev_rise && (bit_cnt < `SEECM_BITS_DONE))
        begin
            shift <= {shift[6:0], pins.sda};
        end
    end

    // ack flag: own ack for address byte, controller ack for read data
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            mack <= 1'b0;
        end
        else if (ack_fall && (state == SEECM_DEV))
        begin
            mack <= addr_match;
        end
        else if (ev_rise && (bit_cnt == `SEECM_BITS_DONE) && (state == SEECM_RDATA))
        begin
            mack <= ~pins.sda;
        end
    end

    // data line drive, decided on the event edge to keep latency short
    always_comb
    begin
        next_drive = ~SDA_OE_N;
        if (ev_start || ev_stop || in_prog)
        begin
            next_drive = 1'b0;
        end
        else if (ack_fall)
        begin
            case (state)
                SEECM_DEV: next_drive = addr_match;
                SEECM_WADDR: next_drive = 1'b1;
                SEECM_WDATA: next_drive = 1'b1;
                default: next_drive = 1'b0;
            endcase
        end
        else if (load_rd)
        begin
            next_drive = ~mem[addr][7];
        end
        else if (slot_end)
        begin
            next_drive = 1'b0;
        end
        else if (ev_fall && (state == SEECM_RDATA) && (bit_cnt != 4'h0))
        begin
            next_drive = ~tx[3'(4'h7 - bit_cnt)];
        end
    end

    // transmit byte holder
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            tx <= 8'h00;
        end
        else if (load_rd)
        begin
            tx <= mem[addr];
        end
    end

    // internal address counter
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            addr <= 8'h00;
        end
        else if (ack_fall && (state == SEECM_WADDR))
        begin
            addr <= shift;
        end
        else if (ack_fall && (state == SEECM_WDATA))
        begin
            addr <= col_next(addr);
        end
        else if (load_rd)
        begin
            addr <= addr + 8'h01;
        end
    end

    // page buffer with loaded-column marks
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            pvalid <= 16'h0000;
        end
        else if (ev_start || prog_done || (ev_stop && !go_prog))
        begin
            pvalid <= 16'h0000;
        end
        else if (ack_fall && (state == SEECM_WDATA))
        begin
            pvalid[addr[`SEECM_COL_W-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (ack_fall && (state == SEECM_WDATA))
        begin
            pbuf[addr[`SEECM_COL_W-1:0]] <= shift;
        end
    end

    // array commit at the end of the programming time
    always_ff @(posedge CLOCK)
    begin
        if (prog_done)
        begin
            for (int i = 0; i < `SEECM_PAGE_BYTES; i++)
            begin
                if (pvalid[i])
                begin
                    mem[{addr[`SEECM_ADDR_W-1:`SEECM_COL_W], 4'(i)}] <= pbuf[i];
                end
            end
        end
    end

    // self-timed programming interval
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            timer <= 32'h0;
        end
        else if (in_prog)
        begin
            timer <= timer + 32'h1;
        end
        else
        begin
            timer <= 32'h0;
        end
    end

    // pin outputs from flops
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            SDA_OUT <= 1'b0;
            SDA_OE_N <= 1'b1;
            BUSY <= 1'b0;
        end
        else
        begin
            SDA_OUT <= 1'b0;
            SDA_OE_N <= ~next_drive;
            BUSY <= (next_state == SEECM_PROG);
        end
    end
endmodule

`default_nettype wire

// >>> tb/seecm_bus_ctl.sv
// Purpose: two-wire bus controller model
// Assumes: called at a CLOCK falling edge
// Notes: data line released means pulled high
`timescale 1ns/1ps
`default_nettype none

module seecm_bus_ctl
(
    output logic scl, // bus clock, high when idle
    output logic sda_oe_n, // low pulls data low
    input wire logic sda // resolved data wire
);
    // 400 ns bit: long low half leaves room for the target's reply
    localparam time LEAD = 50;
    localparam time LOW_REST = 250;
    localparam time HIGH_HALF = 100;
    localparam time GAP = 200;
    initial
    begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end
    task automatic start();
        #(GAP/2) sda_oe_n = 1'b1;
        #GAP scl = 1'b1;
        #GAP sda_oe_n = 1'b0;
        #GAP scl = 1'b0;
    endtask
    task automatic stop();
        #(GAP/2) sda_oe_n = 1'b0;
        #GAP scl = 1'b1;
        #GAP sda_oe_n = 1'b1;
        #GAP;
    endtask
    // nine bits, msb first; data set early in low half, sampled in high half
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            #LEAD sda_oe_n = d[i];
            #LOW_REST scl = 1'b1;
            #(HIGH_HALF/2) r[i] = sda;
            #(HIGH_HALF/2) scl = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// >>> tb/seecm_core_monitor.sv
// Purpose: port assertions of the command engine
// Assumes: one clock domain
// Notes: bound to seecm_core
`timescale 1ns/1ps
`default_nettype none

module seecm_core_monitor
#(
    parameter int PROG_CYCLES = 20
)
(
    input wire logic CLOCK, // core clock
    input wire logic NRST, // async reset, low
    input wire logic SCL_IN, // bus clock pin
    input wire logic SDA_IN, // data wire level
    input wire logic SDA_OUT, // data drive value
    input wire logic SDA_OE_N, // low while pulling
    input wire logic WRITE_PROTECT, // blocks programming
    input wire logic BUSY // programming active
);
    int busy_len;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            busy_len <= 0;
        else if (BUSY)
            busy_len <= busy_len + 1;
        else
            busy_len <= 0;
    end
    open_drain_a: assert property (SDA_OUT == 1'b0)
        else $error("data driven high");
    drive_clock_low_a: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
        else $error("drive changed while clock high");
    drive_after_fall_a: assert property ($fell(SCL_IN) |-> $stable(SDA_OE_N)[*3])
        else $error("drive changed too soon");
    ack_hold_a: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N[*6])
        else $error("low drive too short");
    busy_silent_a: assert property (BUSY |-> SDA_OE_N)
        else $error("drive while programming");
    prog_length_a: assert property ($fell(BUSY) |->
        (busy_len >= PROG_CYCLES - 1 && busy_len <= PROG_CYCLES + 1))
        else $error("programming time wrong");
    protect_no_prog_a: assert property ($rose(BUSY) |-> !WRITE_PROTECT)
        else $error("programming while protected");
    prog_after_stop_a: assert property ($rose(BUSY) |-> SCL_IN && SDA_IN)
        else $error("programming without stop");
    cover property ($rose(BUSY));
    cover property ($fell(SDA_OE_N) ##[1:20] SCL_IN);
    cover property ($fell(BUSY));
endmodule

bind seecm_core seecm_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) watch (.CLOCK(CLOCK),
    .NRST(NRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .WRITE_PROTECT(WRITE_PROTECT), .BUSY(BUSY));

`default_nettype wire

// >>> tb/serial_eeprom_command_engine_tb_top.sv
// Purpose: self-checking bench of the command engine
// Assumes: data wire pulled high
// Notes: short programming time
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_command_engine_tb_top;
    import seecm_pkg::*;
    localparam int PROG = 400;
    localparam logic [3:0] TCODE = 4'h5; // arbitrary value
    localparam logic [2:0] SEL = 3'h5;
    logic CLOCK = 1'b0;
    logic NRST = 1'b0;
    logic WRITE_PROTECT = 1'b0;
    logic SDA_OUT, SDA_OE_N, BUSY, scl, ctl_oe_n;
    wire logic sda;
    int bad_count = 0;
    int cmp_count = 0;
    assign sda = ctl_oe_n & (SDA_OE_N | SDA_OUT);
    seecm_bus_ctl ctl (.scl(scl), .sda_oe_n(ctl_oe_n), .sda(sda));
    seecm_core #(.PROG_CYCLES(PROG), .TYPE_CODE(TCODE)) DUT (.CLOCK(CLOCK), .NRST(NRST),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
        .CHIP_SELECT_PINS(SEL), .WRITE_PROTECT(WRITE_PROTECT), .BUSY(BUSY));
    initial
    begin
        forever #25 CLOCK = ~CLOCK;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic put(input seecm_byte_t b, input logic ack, input string what);
        logic [8:0] r;
        ctl.xfer({b, 1'b1}, r);
        check(what, {7'h0, ~r[0]}, {7'h0, ack});
    endtask
    task automatic get(input logic more, output seecm_byte_t v);
        logic [8:0] r;
        ctl.xfer({8'hff, ~more}, r);
        v = r[8:1];
    endtask
    function automatic seecm_byte_t dev(input logic rd, input logic [2:0] s);
        return {TCODE, s, rd};
    endfunction
    task automatic point(input seecm_byte_t a);
        ctl.start();
        put(dev(1'b0, SEL), 1'b1, "write select ack");
        put(a, 1'b1, "word address ack");
    endtask
    task automatic rd_at(input seecm_byte_t a, input seecm_byte_t exp);
        seecm_byte_t v;
        point(a);
        ctl.start();
        put(dev(1'b1, SEL), 1'b1, "read select ack");
        get(1'b0, v);
        ctl.stop();
        check("random read", v, exp);
        check("dummy write busy", {7'h0, BUSY}, 8'h00);
    endtask
    task automatic wr_at(input seecm_byte_t a, input seecm_byte_t v);
        point(a);
        put(v, 1'b1, "data ack");
        ctl.stop();
    endtask
    task automatic settle();
        repeat (8) @(negedge CLOCK);
        check("busy after stop", {7'h0, BUSY}, 8'h01);
        for (int n = 0; n < 2 * PROG && BUSY !== 1'b0; n++)
            @(negedge CLOCK);
        check("busy end", {7'h0, BUSY}, 8'h00);
    endtask
    task automatic t_byte();
        wr_at(8'h35, 8'ha7);
        repeat (8) @(negedge CLOCK);
        check("busy after stop", {7'h0, BUSY}, 8'h01);
        ctl.start();
        put(dev(1'b0, SEL), 1'b0, "poll while busy");
        ctl.stop();
        settle();
        ctl.start();
        put(dev(1'b0, SEL), 1'b1, "poll when ready");
        ctl.stop();
        rd_at(8'h35, 8'ha7);
        $display("byte write test done");
    endtask
    task automatic t_sel();
        for (int i = 0; i < 4; i++)
        begin
            ctl.start();
            if (i < 3)
                put(dev(1'b0, SEL ^ (3'h1 << i)), 1'b0, "foreign select");
            else
                put({4'h3, SEL, 1'b1}, 1'b0, "foreign type");
            ctl.stop();
        end
        check("busy after refusal", {7'h0, BUSY}, 8'h00);
        $display("select test done");
    endtask
    task automatic t_page();
        seecm_byte_t v;
        point(8'h4e);
        for (int i = 0; i < 18; i++)
            put(8'h10 + i[7:0], 1'b1, "page data ack");
        ctl.stop();
        settle();
        point(8'h40);
        ctl.start();
        put(dev(1'b1, SEL), 1'b1, "read select ack");
        for (int c = 0; c < 16; c++)
        begin
            get(c < 15, v);
            check("page column", v, 8'h12 + c[7:0]);
        end
        ctl.stop();
        $display("page write test done");
    endtask
    task automatic t_wrap();
        seecm_byte_t v;
        wr_at(8'hff, 8'h5c);
        settle();
        wr_at(8'h00, 8'hc3);
        settle();
        rd_at(8'hff, 8'h5c);
        ctl.start();
        put(dev(1'b1, SEL), 1'b1, "current read ack");
        get(1'b0, v);
        ctl.stop();
        check("wrapped counter read", v, 8'hc3);
        $display("wrap test done");
    endtask
    task automatic t_wp();
        WRITE_PROTECT = 1'b1;
        wr_at(8'h35, 8'h11);
        repeat (8) @(negedge CLOCK);
        check("busy under protect", {7'h0, BUSY}, 8'h00);
        rd_at(8'h35, 8'ha7);
        WRITE_PROTECT = 1'b0;
        point(8'h35);
        put(8'h66, 1'b1, "abandoned data ack");
        wr_at(8'h36, 8'h77);
        settle();
        rd_at(8'h35, 8'ha7);
        rd_at(8'h36, 8'h77);
        $display("protect test done");
    endtask
    initial
    begin
        repeat (3) @(negedge CLOCK);
        NRST = 1'b1;
        repeat (6) @(negedge CLOCK);
        check("idle outputs", {5'h0, SDA_OUT, SDA_OE_N, BUSY}, 8'h02);
        t_byte();
        t_sel();
        t_page();
        t_wrap();
        t_wp();
        end_of_test();
    end
    initial
    begin
        #3ms;
        bad_count++;
        end_of_test();
    end
endmodule

`default_nettype wire
